// >>> pdp_pkg.sv
// Shared types and constants for the PCIe/DMA performance counters
package pdp_pkg;
	localparam int CLK_HZ          = 100_000_000;
	localparam int CLK_PERIOD_NS   = 10;
	localparam int INTERVAL_NS     = 1_000_000_000;
	localparam int INTERVAL_CYC    = INTERVAL_NS / CLK_PERIOD_NS;
	localparam int CNT_W           = 32;
	localparam int TIMER_W         = 32;
	localparam int NUM_ENG         = 4;
	localparam int AXI_DW          = 64;
	localparam int KEEP_W          = AXI_DW / 8;
	localparam int BYTES_W         = 4;
	localparam int DMA_BYTES_W     = 16;
	localparam logic [4:0] TYPE_MWR  = 5'h0_0;
	localparam logic [4:0] TYPE_CPL  = 5'h0_A;
	// Data-present flag within the two fmt bits
	localparam logic [1:0] FMT_DATA  = 2'h2;
	localparam int FMT_LO          = 29;
	localparam int TYPE_LO         = 24;
	localparam int HDR_DW_3        = 3;
	localparam int HDR_DW_4        = 4;

	// One beat of an endpoint AXI-Stream transaction interface
	typedef struct packed {
		logic              tvalid;
		logic              tready;
		logic              tlast;
		logic [KEEP_W-1:0] tkeep;
		logic [AXI_DW-1:0] tdata;
	} pdp_axis_t;

	// Payload delivered by one DMA engine in one cycle
	typedef struct packed {
		logic                   valid;
		logic [DMA_BYTES_W-1:0] bytes;
	} pdp_dma_beat_t;

	typedef enum logic [1:0] {
		TLP_IDLE,
		TLP_BODY
	} pdp_tlp_state_t;
endpackage

// >>> pdp_perf_counters.sv
// PCIe transaction-interface and DMA engine throughput counters
//
// Summary of operation
// - Each DMA engine has its own count of payload bytes it hands on.
// - Tx utilization sums every byte on the transmit stream, headers too.
// - Rx utilization sums every byte on the receive stream, headers too.
// - Tx payload sums only payload of upstream memory writes of any kind.
// - Rx payload sums only payload of downstream completions with data.
// - All readable counts refresh once per interval of one second.
`timescale 1ns/1ps
module pdp_perf_counters #(
	parameter int INTERVAL = pdp_pkg::INTERVAL_CYC
) (
	input  wire logic                  ref_clk_i,
	input  wire logic                  rst_n_i,
	input  wire pdp_pkg::pdp_axis_t    tx_axis_i,
	input  wire pdp_pkg::pdp_axis_t    rx_axis_i,
	input  wire pdp_pkg::pdp_dma_beat_t dma_beat_i [pdp_pkg::NUM_ENG],
	output logic [pdp_pkg::CNT_W-1:0]  tx_util_o,
	output logic [pdp_pkg::CNT_W-1:0]  rx_util_o,
	output logic [pdp_pkg::CNT_W-1:0]  tx_payload_o,
	output logic [pdp_pkg::CNT_W-1:0]  rx_payload_o,
	output logic [pdp_pkg::CNT_W-1:0]  dma_bytes_o [pdp_pkg::NUM_ENG],
	output logic                       update_o
);
	localparam int CW = pdp_pkg::CNT_W;
	localparam int BW = pdp_pkg::BYTES_W;
	// A 4DW header is 16 bytes, one bit more than a beat count needs
	localparam int HW = pdp_pkg::BYTES_W + 1;

	// Counts enabled byte lanes of one beat
	function automatic logic [BW-1:0] keep_bytes(
		input logic [pdp_pkg::KEEP_W-1:0] keep
	);
		logic [BW-1:0] n;
		n = '0;
		for (int i = 0; i < pdp_pkg::KEEP_W; i++) begin
			n = n + BW'(keep[i]);
		end
		return n;
	endfunction

	// Header length in bytes taken from the first header dword
	function automatic logic [HW-1:0] hdr_bytes(input logic [31:0] dw0);
		logic [HW-1:0] n;
		n = dw0[pdp_pkg::FMT_LO] ? HW'(pdp_pkg::HDR_DW_4 * 4)
			: HW'(pdp_pkg::HDR_DW_3 * 4);
		return n;
	endfunction

	// Interval timer
	logic [pdp_pkg::TIMER_W-1:0] timer;
	logic                        tick;
	assign tick = (timer == pdp_pkg::TIMER_W'(INTERVAL - 1));

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			timer <= '0;
		end else if (tick) begin
			timer <= '0;
		end else begin
			timer <= timer + 1'b1;
		end
	end

	// Per-direction TLP tracking and counting
	logic [CW-1:0] run_util   [2];
	logic [CW-1:0] run_pay    [2];
	logic [CW-1:0] shown_util [2];
	logic [CW-1:0] shown_pay  [2];

	generate
		for (genvar d = 0; d < 2; d++) begin : g_dir
			pdp_pkg::pdp_axis_t    bus;
			pdp_pkg::pdp_tlp_state_t st;
			logic                  is_pay;
			logic                  first_pay;
			logic                  beat;
			logic [BW-1:0]         nbytes;
			logic [BW-1:0]         next_pay;
			logic [HW-1:0]         hdr_left;
			logic [HW-1:0]         hdr_need;
			logic [HW-1:0]         hdr_eat;
			logic [HW-1:0]         next_hdr_left;
			logic [1:0]            fmt;
			logic [4:0]            typ;
			logic                  match;

			assign bus   = (d == 0) ? tx_axis_i : rx_axis_i;
			assign beat  = bus.tvalid && bus.tready;
			assign nbytes = keep_bytes(bus.tkeep);
			assign fmt   = bus.tdata[pdp_pkg::FMT_LO +: 2];
			assign typ   = bus.tdata[pdp_pkg::TYPE_LO +: 5];
			// Transmit counts memory writes, receive counts completions
			assign match = ((fmt & pdp_pkg::FMT_DATA) != 2'h0) &&
				(typ == ((d == 0) ? pdp_pkg::TYPE_MWR : pdp_pkg::TYPE_CPL));

			// A 64-bit beat never holds a whole header, so the header
			// bytes still owed are carried over into the next beats.
			always_comb begin
				hdr_need = (st == pdp_pkg::TLP_IDLE)
					? hdr_bytes(bus.tdata[31:0]) : hdr_left;
				hdr_eat = (HW'(nbytes) < hdr_need) ? HW'(nbytes) : hdr_need;
				next_hdr_left = hdr_need - hdr_eat;
				next_pay = '0;
				if ((st == pdp_pkg::TLP_IDLE) ? match : is_pay) begin
					next_pay = BW'(HW'(nbytes) - hdr_eat);
				end
			end
			assign first_pay = match;

			always_ff @(posedge ref_clk_i) begin
				if (!rst_n_i) begin
					st     <= pdp_pkg::TLP_IDLE;
					is_pay <= 1'b0;
					hdr_left <= '0;
				end else if (beat) begin
					hdr_left <= next_hdr_left;
					case (st)
						pdp_pkg::TLP_IDLE: begin
							if (!bus.tlast) begin
								st     <= pdp_pkg::TLP_BODY;
								is_pay <= first_pay;
							end
						end
						pdp_pkg::TLP_BODY: begin
							if (bus.tlast) begin
								st     <= pdp_pkg::TLP_IDLE;
								is_pay <= 1'b0;
							end
						end
						default: begin
							st     <= pdp_pkg::TLP_IDLE;
							is_pay <= 1'b0;
						end
					endcase
				end
			end

			always_ff @(posedge ref_clk_i) begin
				if (!rst_n_i) begin
					run_util[d]   <= '0;
					run_pay[d]    <= '0;
					shown_util[d] <= '0;
					shown_pay[d]  <= '0;
				end else if (tick) begin
					// Beat in the boundary cycle lands in the closing interval
					shown_util[d] <= run_util[d] + (beat ? CW'(nbytes) : '0);
					shown_pay[d]  <= run_pay[d] + (beat ? CW'(next_pay) : '0);
					run_util[d]   <= '0;
					run_pay[d]    <= '0;
				end else if (beat) begin
					run_util[d] <= run_util[d] + CW'(nbytes);
					run_pay[d]  <= run_pay[d] + CW'(next_pay);
				end
			end
		end
	endgenerate

	assign tx_util_o    = shown_util[0];
	assign rx_util_o    = shown_util[1];
	assign tx_payload_o = shown_pay[0];
	assign rx_payload_o = shown_pay[1];

	// DMA engine payload counters
	logic [CW-1:0] run_dma [pdp_pkg::NUM_ENG];

	generate
		for (genvar e = 0; e < pdp_pkg::NUM_ENG; e++) begin : g_eng
			logic [CW-1:0] add;
			assign add = dma_beat_i[e].valid ? CW'(dma_beat_i[e].bytes) : '0;
			always_ff @(posedge ref_clk_i) begin
				if (!rst_n_i) begin
					run_dma[e]     <= '0;
					dma_bytes_o[e] <= '0;
				end else if (tick) begin
					dma_bytes_o[e] <= run_dma[e] + add;
					run_dma[e]     <= '0;
				end else begin
					run_dma[e] <= run_dma[e] + add;
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			update_o <= 1'b0;
		end else begin
			update_o <= tick;
		end
	end

	// Boundary cycle, then a one-cycle pulse with the util, payload and engine 0 run counts at zero
	sequence s_boundary;
		tick;
	endsequence

	sequence s_restarted;
		update_o && run_util[0] == '0 && run_util[1] == '0
			&& run_pay[0] == '0 && run_pay[1] == '0
			&& run_dma[0] == '0;
	endsequence

	property p_update_period;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		update_o |=> !update_o;
	endproperty

	property p_run_cleared;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_boundary |=> s_restarted;
	endproperty

	property p_stable;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		!update_o && !$past(tick) |-> $stable(tx_util_o)
			&& $stable(rx_util_o) && $stable(tx_payload_o)
			&& $stable(rx_payload_o) && $stable(dma_bytes_o[0]);
	endproperty

	property p_pay_le_util_tx;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		tx_payload_o <= tx_util_o;
	endproperty

	property p_pay_le_util_rx;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		rx_payload_o <= rx_util_o;
	endproperty

	property p_tx_accum;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		!tick && tx_axis_i.tvalid && tx_axis_i.tready |=>
			run_util[0] == $past(run_util[0])
				+ CW'(keep_bytes($past(tx_axis_i.tkeep)));
	endproperty

	property p_rx_accum;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		!tick && rx_axis_i.tvalid && rx_axis_i.tready |=>
			run_util[1] == $past(run_util[1])
				+ CW'(keep_bytes($past(rx_axis_i.tkeep)));
	endproperty

	property p_dma_idle;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		!tick && !dma_beat_i[0].valid |=> $stable(run_dma[0]);
	endproperty

	AST_UPDATE_PERIOD: assert property (p_update_period)
		else $error("update pulse longer than one cycle");

	AST_RUN_CLEARED: assert property (p_run_cleared)
		else $error("running count not restarted at boundary");

	AST_STABLE: assert property (p_stable)
		else $error("reading changed between updates");

	AST_PAY_LE_UTIL_TX: assert property (p_pay_le_util_tx)
		else $error("tx payload exceeds tx utilization");

	AST_PAY_LE_UTIL_RX: assert property (p_pay_le_util_rx)
		else $error("rx payload exceeds rx utilization");

	AST_TX_ACCUM: assert property (p_tx_accum)
		else $error("tx utilization missed bytes");

	AST_RX_ACCUM: assert property (p_rx_accum)
		else $error("rx utilization missed bytes");

	AST_DMA_IDLE: assert property (p_dma_idle)
		else $error("dma counter moved without payload");
endmodule

// >>> pdp_link_model.sv
// Endpoint transaction streams and DMA engines facing the counters
`timescale 1ns/1ps
module pdp_link_model (
	input  wire logic                   ref_clk_i,
	output pdp_pkg::pdp_axis_t          tx_o,
	output pdp_pkg::pdp_axis_t          rx_o,
	output pdp_pkg::pdp_dma_beat_t      dma_o [pdp_pkg::NUM_ENG]
);
	// Idle lines carry junk so stale data never passes for a beat
	function automatic pdp_pkg::pdp_axis_t junk();
		junk = {1'b0, 1'($urandom), 1'b0, 8'($urandom), $urandom, $urandom};
	endfunction
	initial begin
		tx_o = junk();
		rx_o = junk();
		foreach (dma_o[e]) dma_o[e] = '0;
	end
	task automatic put(input bit rx, input pdp_pkg::pdp_axis_t b);
		@(posedge ref_clk_i);
		if (rx) rx_o <= b;
		else tx_o <= b;
	endtask
	// One TLP, last beat partial when length is not a multiple of 8, a stall of one cycle at random
	task automatic send(input bit rx, input logic [1:0] fmt,
			input logic [4:0] typ, input int pay);
		pdp_pkg::pdp_axis_t b;
		int left;
		left = (fmt[0] ? 16 : 12) + pay;
		for (int i = 0; left > 0; i++) begin
			b = junk();
			b.tvalid = 1'b1;
			b.tlast = (left <= 8);
			b.tkeep = (left >= 8) ? 8'hFF : 8'hFF >> (8 - left);
			if (i == 0) b.tdata[31:0] = {1'b0, fmt, typ, 24'h00_0000};
			put(rx, b);
			if (!b.tready) begin
				b.tready = 1'b1;
				put(rx, b);
			end
			left -= 8;
		end
		put(rx, junk());
	endtask
	task automatic dma_put(input logic [3:0] v, input logic [15:0] n [4]);
		@(posedge ref_clk_i);
		foreach (dma_o[e]) dma_o[e] <= {v[e], n[e]};
	endtask
endmodule

// >>> pdp_perf_counters_tb.sv
// Self-checking bench for the throughput counters
`timescale 1ns/1ps
module pdp_perf_counters_tb;
	localparam int IVL = 16;
	typedef logic [7:0][31:0] pdp_exp_t;
	logic                   ref_clk_i;
	logic                   rst_n_i;
	logic                   upd;
	pdp_pkg::pdp_axis_t     tx;
	pdp_pkg::pdp_axis_t     rx;
	pdp_pkg::pdp_dma_beat_t dma [pdp_pkg::NUM_ENG];
	logic [31:0]            cnt [4];
	logic [31:0]            dcnt [pdp_pkg::NUM_ENG];
	pdp_exp_t               obs;
	pdp_exp_t               s;
	pdp_exp_t               last;
	pdp_exp_t               q [$];
	int                     fail_count = 0;
	int                     comparisons = 0;
	string nm [8] = '{"tx_util", "rx_util", "tx_pay", "rx_pay",
		"dma0", "dma1", "dma2", "dma3"};
	logic [6:0] tk [3] = '{7'h40, 7'h60, 7'h00};
	logic [6:0] rk [3] = '{7'h4A, 7'h0A, 7'h40};
	assign obs = {dcnt[3], dcnt[2], dcnt[1], dcnt[0],
		cnt[3], cnt[2], cnt[1], cnt[0]};
	pdp_perf_counters #(.INTERVAL(IVL)) dut (.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i), .tx_axis_i(tx), .rx_axis_i(rx),
		.dma_beat_i(dma), .tx_util_o(cnt[0]), .rx_util_o(cnt[1]),
		.tx_payload_o(cnt[2]), .rx_payload_o(cnt[3]),
		.dma_bytes_o(dcnt), .update_o(upd));
	pdp_link_model lm (.ref_clk_i(ref_clk_i), .tx_o(tx), .rx_o(rx),
		.dma_o(dma));
	task automatic check(input string what, input logic [255:0] exp,
			input logic [255:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Header is 12 or 16 bytes; payload counts only writes up, data back
	task automatic tlp(input bit rx, input logic [6:0] k, input int p);
		int pl;
		pl = k[6] ? p : 0;
		s[rx] += (k[5] ? 16 : 12) + pl;
		if (k[6] && k[4:0] == (rx ? 5'h0A : 5'h00)) s[2 + rx] += pl;
		lm.send(rx, k[6:5], k[4:0], pl);
	endtask
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	initial begin
		repeat (1000) @(posedge ref_clk_i);
		fail_count++;
		give_verdict();
	end
	initial begin
		int gap;
		gap = -100;
		last = '0;
		@(posedge rst_n_i);
		forever begin
			@(negedge ref_clk_i);
			gap++;
			if (upd === 1'b1) begin
				last = q.pop_front();
				for (int i = 0; i < 8; i++) begin
					check(nm[i], last[i], obs[i]);
				end
				if (gap > 0) check("interval", IVL, gap);
				gap = 0;
			end else check("hold", last, obs);
		end
	end
	initial begin
		logic [15:0] n [4];
		logic [3:0]  v;
		int          p;
		rst_n_i = 1'b0;
		void'($urandom(63813));
		q.push_back('0);
		repeat (8) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		for (int t = 0; t < 9; t++) begin
			@(negedge ref_clk_i iff upd === 1'b1);
			s = '0;
			p = 4 * (1 + $urandom % 4);
			fork
				tlp(0, tk[t % 3], p);
				tlp(1, rk[t % 3], p);
				begin
					for (int c = 0; c < 4; c++) begin
						v = 4'($urandom);
						foreach (n[e]) begin
							n[e] = 16'($urandom);
							if (v[e]) s[4 + e] += n[e];
						end
						lm.dma_put(v, n);
					end
					// Drop valid at once so the last word counts only once
					lm.dma_put(4'h0, n);
				end
			join
			q.push_back(s);
			$display("test %0d done", t);
		end
		@(negedge ref_clk_i iff upd === 1'b1);
		repeat (2) @(negedge ref_clk_i);
		give_verdict();
	end
endmodule
